// ### design/mem_select_map.svh
// Register offsets, field positions, reset values and bound encodings for the memory select decoder
`ifndef MEM_SELECT_MAP_SVH
`define MEM_SELECT_MAP_SVH

// Register indexes; each register is one aligned word, so its APB byte
// address is four times its index
`define UPPER_CFG_IDX      10'h3A0
`define LOWER_CFG_IDX      10'h3A2
`define STATUS_IDX         10'h3A4
`define CYCLE_IDX          10'h3A8
`define SYSCFG_IDX         10'h3AC
`define UPPER_CFG_ADDR     {`UPPER_CFG_IDX, 2'b00}
`define LOWER_CFG_ADDR     {`LOWER_CFG_IDX, 2'b00}
`define STATUS_ADDR        {`STATUS_IDX, 2'b00}
`define CYCLE_ADDR         {`CYCLE_IDX, 2'b00}
`define SYSCFG_ADDR        {`SYSCFG_IDX, 2'b00}

// Field positions shared by both region registers
`define FLD_BOUND_HI       14
`define FLD_BOUND_LO       12
`define FLD_ADDR_OFF       7
`define FLD_DRAM_ON        6
`define FLD_WIDTH          5
`define FLD_READY_IGN      2
`define FLD_WAIT_HI        1
`define FLD_WAIT_LO        0

// Writable bit masks
`define CFG_WR_MASK        16'h70E7

// Reset values
`define UPPER_CFG_RESET    16'hF01B
`define LOWER_CFG_RESET    16'h0F1B

// Region bound encodings
`define UPPER_FLOOR_64K    3'b111
`define UPPER_FLOOR_128K   3'b110
`define UPPER_FLOOR_256K   3'b100
`define UPPER_FLOOR_512K   3'b000
`define LOWER_TOP_64K      3'b000
`define LOWER_TOP_128K     3'b001
`define LOWER_TOP_256K     3'b011
`define LOWER_TOP_512K     3'b111

// Start of each upper block and end of each lower block, address bits 19:16
`define UPPER_BASE_64K     4'hF
`define UPPER_BASE_128K    4'hE
`define UPPER_BASE_256K    4'hC
`define UPPER_BASE_512K    4'h8
`define LOWER_END_64K      4'h0
`define LOWER_END_128K     4'h1
`define LOWER_END_256K     4'h3
`define LOWER_END_512K     4'h7

// Syscfg bit for global memory address disable
`define FLD_GLOBAL_OFF     0

`endif

// ### design/mem_select_pkg.sv
// Types for the memory select decoder
package mem_select_pkg;
  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_UPPER,
    REGION_LOWER,
    REGION_PERIPH
  } region_t;
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_ADDR,
    CYC_WAIT,
    CYC_DATA
  } cyc_state_t;
endpackage : mem_select_pkg

// ### design/region_cfg_if.sv
// Decoded view of one region control register shared between decoder modules
`timescale 1ns/100ps
interface region_cfg_if;
  logic [2:0] bound;
  logic       addr_phase_off;
  logic       dram_on;
  logic       width_sel;
  logic       ready_ignore;
  logic [1:0] wait_count;
  logic       hit;
  logic [3:0] addr_top;
  modport src (output bound, output addr_phase_off, output dram_on, output width_sel,
               output ready_ignore, output wait_count, input hit, output addr_top);
  modport cmp (input bound, input addr_top, input dram_on, output hit);
endinterface : region_cfg_if

// ### design/region_match.sv
// Address range comparator for one memory region
`timescale 1ns/100ps
`include "mem_select_map.svh"
module region_match #(
  parameter bit IS_UPPER = 1'b1
) (
  region_cfg_if.cmp cfg
);
  logic [3:0] limit;

  // Upper region ends at FFFFFh, lower region starts at 00000h
  always_comb begin
    limit = 4'h0;
    if (IS_UPPER) begin
      case (cfg.bound)
        `UPPER_FLOOR_64K:  limit = `UPPER_BASE_64K;
        `UPPER_FLOOR_128K: limit = `UPPER_BASE_128K;
        `UPPER_FLOOR_256K: limit = `UPPER_BASE_256K;
        `UPPER_FLOOR_512K: limit = `UPPER_BASE_512K;
        default:           limit = `UPPER_BASE_64K;
      endcase
      cfg.hit = (cfg.addr_top >= limit);
    end else begin
      case (cfg.bound)
        `LOWER_TOP_64K:  limit = `LOWER_END_64K;
        `LOWER_TOP_128K: limit = `LOWER_END_128K;
        `LOWER_TOP_256K: limit = `LOWER_END_256K;
        `LOWER_TOP_512K: limit = `LOWER_END_512K;
        default:         limit = `LOWER_END_64K;
      endcase
      cfg.hit = (cfg.addr_top <= limit);
    end
  end
endmodule : region_match

// ### design/memory_chip_select_decoder.sv
// Upper and lower memory region select decoder with APB register access
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "mem_select_map.svh"

// Overview of operation
// - Drive address phase unless region disables it
// - Address-disable ignored when enable strap low
// - Peripheral overlap on DRAM still drives address
// - Upper DRAM: remap midrange selects, hold upper
// - Upper region resets as non-DRAM bank
// - DRAM mode ignores ready, forces 16-bit
// - Peripheral overlap on DRAM uses 16-bit
// - Width bit: 0 is 16-bit, 1 is 8-bit
// - External reset loads inverted byte-boot strap
// - Watchdog reset keeps strap and width bit
// - Ready-ignore bit gates external ready inputs
// - Wait field adds zero to three waits
// - Lower select off until register written
// - Lower region from zero, four top codes
// - Lower DRAM: lower select becomes row strobe
// - Upper region ends at top, four sizes
// - Upper select active straight after reset
module memory_chip_select_decoder
  import mem_select_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources and straps
  input  wire logic        watchdog_reset,
  input  wire logic        addr_enable_strap_n,
  input  wire logic        byte_boot_strap,
  // Processor cycle request
  input  wire logic        cycle_start,
  input  wire logic [19:0] cycle_addr,
  input  wire logic        peripheral_select,
  // External ready
  input  wire logic        sync_ready_in,
  input  wire logic        async_ready_in,
  // Memory side
  output logic             upper_select_out_n,
  output logic             lower_select_out_n,
  output logic             midrange_select_one_n,
  output logic             midrange_select_two_n,
  output logic             midrange_select_three_n,
  output logic             addr_drive_en,
  output logic             bus_is_x8,
  output logic             data_phase,
  output logic             cycle_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] upper_region_select_cfg_r;
  logic [15:0] lower_region_select_cfg_r;
  logic        lower_written_r;
  logic        global_mem_addr_off_r;
  logic        strap_taken_r;
  logic        addr_strap_low_r;
  logic        width_locked_r;
  logic        apb_wr;
  logic        apb_rd;
  logic [15:0] wmask;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // A locked width bit cannot be changed by software
  assign wmask = width_locked_r ? (`CFG_WR_MASK & ~(16'h0001 << `FLD_WIDTH)) : `CFG_WR_MASK;

  // Straps are caught on the first clock after external reset release only;
  // the watchdog does not rearm this, so width and strap stay as they were
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken_r    <= 1'b0;
      addr_strap_low_r <= 1'b0;
      width_locked_r   <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r    <= 1'b1;
      addr_strap_low_r <= !addr_enable_strap_n;
      width_locked_r   <= byte_boot_strap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_region_select_cfg_r <= `UPPER_CFG_RESET;
    end else if (!strap_taken_r) begin
      upper_region_select_cfg_r[`FLD_WIDTH] <= !byte_boot_strap;
    end else if (watchdog_reset) begin
      // Width bit survives the watchdog; the rest reloads
      upper_region_select_cfg_r <= (`UPPER_CFG_RESET & ~(16'h0001 << `FLD_WIDTH)) |
                                   (upper_region_select_cfg_r & (16'h0001 << `FLD_WIDTH));
    end else if (apb_wr && paddr == `UPPER_CFG_ADDR) begin
      upper_region_select_cfg_r <= (upper_region_select_cfg_r & ~wmask) |
                                   (pwdata[15:0] & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_region_select_cfg_r <= `LOWER_CFG_RESET;
      lower_written_r           <= 1'b0;
    end else if (watchdog_reset) begin
      lower_region_select_cfg_r <= `LOWER_CFG_RESET;
      lower_written_r           <= 1'b0;
    end else if (apb_wr && paddr == `LOWER_CFG_ADDR) begin
      lower_region_select_cfg_r <= (lower_region_select_cfg_r & ~`CFG_WR_MASK) |
                                   (pwdata[15:0] & `CFG_WR_MASK);
      lower_written_r           <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_mem_addr_off_r <= 1'b0;
    end else if (apb_wr && paddr == `SYSCFG_ADDR) begin
      global_mem_addr_off_r <= pwdata[`FLD_GLOBAL_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path and answer; one wait-free access phase
  logic       dram_any;
  cyc_state_t state_r;
  region_t    region_r;
  logic [1:0] wait_left_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `UPPER_CFG_ADDR: prdata <= {16'h0000, upper_region_select_cfg_r};
          `LOWER_CFG_ADDR: prdata <= {16'h0000, lower_region_select_cfg_r};
          `STATUS_ADDR:    prdata <= {28'h000_0000, width_locked_r, addr_strap_low_r,
                                      lower_written_r, dram_any};
          `CYCLE_ADDR:     prdata <= {26'h000_0000, wait_left_r, region_r, state_r};
          `SYSCFG_ADDR:    prdata <= {31'h0000_0000, global_mem_addr_off_r};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region decode
  region_cfg_if up_if ();
  region_cfg_if lo_if ();

  assign up_if.bound          = upper_region_select_cfg_r[`FLD_BOUND_HI:`FLD_BOUND_LO];
  assign up_if.addr_phase_off = upper_region_select_cfg_r[`FLD_ADDR_OFF];
  assign up_if.dram_on        = upper_region_select_cfg_r[`FLD_DRAM_ON];
  assign up_if.width_sel      = upper_region_select_cfg_r[`FLD_WIDTH];
  assign up_if.ready_ignore   = upper_region_select_cfg_r[`FLD_READY_IGN];
  assign up_if.wait_count     = upper_region_select_cfg_r[`FLD_WAIT_HI:`FLD_WAIT_LO];
  assign up_if.addr_top       = cycle_addr[19:16];
  assign lo_if.bound          = lower_region_select_cfg_r[`FLD_BOUND_HI:`FLD_BOUND_LO];
  assign lo_if.addr_phase_off = lower_region_select_cfg_r[`FLD_ADDR_OFF];
  assign lo_if.dram_on        = lower_region_select_cfg_r[`FLD_DRAM_ON];
  assign lo_if.width_sel      = lower_region_select_cfg_r[`FLD_WIDTH];
  assign lo_if.ready_ignore   = lower_region_select_cfg_r[`FLD_READY_IGN];
  assign lo_if.wait_count     = lower_region_select_cfg_r[`FLD_WAIT_HI:`FLD_WAIT_LO];
  assign lo_if.addr_top       = cycle_addr[19:16];

  region_match #(.IS_UPPER(1'b1)) u_upper_match (.cfg(up_if));
  region_match #(.IS_UPPER(1'b0)) u_lower_match (.cfg(lo_if));

  assign dram_any = up_if.dram_on || lo_if.dram_on;

  // Peripheral select wins only over a DRAM-mapped region it overlaps
  region_t    hit_region;
  logic       hit_up;
  logic       hit_lo;
  assign hit_up = up_if.hit;
  assign hit_lo = lo_if.hit && lower_written_r;

  always_comb begin
    hit_region = REGION_NONE;
    if (peripheral_select && ((hit_up && up_if.dram_on) || (hit_lo && lo_if.dram_on))) begin
      hit_region = REGION_PERIPH;
    end else if (hit_up) begin
      hit_region = REGION_UPPER;
    end else if (hit_lo) begin
      hit_region = REGION_LOWER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer: address phase, programmed waits, data phase
  logic ready_in;
  logic ready_ign_sel;
  assign ready_in = sync_ready_in && async_ready_in;

  always_comb begin
    case (region_r)
      REGION_UPPER: ready_ign_sel = up_if.ready_ignore || up_if.dram_on;
      REGION_LOWER: ready_ign_sel = lo_if.ready_ignore || lo_if.dram_on;
      default:      ready_ign_sel = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= CYC_IDLE;
      region_r    <= REGION_NONE;
      wait_left_r <= 2'b00;
    end else begin
      case (state_r)
        CYC_IDLE: begin
          if (cycle_start) begin
            state_r  <= CYC_ADDR;
            region_r <= hit_region;
            case (hit_region)
              REGION_UPPER: wait_left_r <= up_if.wait_count;
              REGION_LOWER: wait_left_r <= lo_if.wait_count;
              default:      wait_left_r <= 2'b00;
            endcase
          end
        end
        CYC_ADDR: begin
          state_r <= (wait_left_r != 2'b00) ? CYC_WAIT : CYC_DATA;
        end
        CYC_WAIT: begin
          wait_left_r <= wait_left_r - 2'b01;
          if (wait_left_r == 2'b01) begin
            state_r <= CYC_DATA;
          end
        end
        CYC_DATA: begin
          // External ready can only stretch, never shorten the minimum
          if (ready_in || ready_ign_sel) begin
            state_r  <= CYC_IDLE;
            region_r <= REGION_NONE;
          end
        end
        default: state_r <= CYC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, all registered
  logic addr_off_sel;
  always_comb begin
    case (hit_region)
      REGION_UPPER: addr_off_sel = up_if.addr_phase_off && !addr_strap_low_r;
      REGION_LOWER: addr_off_sel = lo_if.addr_phase_off && !addr_strap_low_r;
      default:      addr_off_sel = 1'b0;
    endcase
  end

  logic in_cycle_nxt;
  logic up_act;
  logic lo_act;
  assign in_cycle_nxt = (state_r == CYC_IDLE) ? cycle_start :
                        !(state_r == CYC_DATA && (ready_in || ready_ign_sel));
  assign up_act = in_cycle_nxt && ((state_r == CYC_IDLE) ? hit_region == REGION_UPPER
                                                         : region_r == REGION_UPPER);
  assign lo_act = in_cycle_nxt && ((state_r == CYC_IDLE) ? hit_region == REGION_LOWER
                                                         : region_r == REGION_LOWER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_select_out_n      <= 1'b1;
      lower_select_out_n      <= 1'b1;
      midrange_select_one_n   <= 1'b1;
      midrange_select_two_n   <= 1'b1;
      midrange_select_three_n <= 1'b1;
    end else begin
      upper_select_out_n      <= !(up_act && !up_if.dram_on);
      lower_select_out_n      <= !lo_act;
      midrange_select_three_n <= !(up_act && up_if.dram_on);
      // Column strobes follow the row strobe of whichever bank is DRAM
      midrange_select_one_n   <= !((up_act && up_if.dram_on) || (lo_act && lo_if.dram_on));
      midrange_select_two_n   <= !((up_act && up_if.dram_on) || (lo_act && lo_if.dram_on));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_drive_en <= 1'b0;
      bus_is_x8     <= 1'b0;
      data_phase    <= 1'b0;
      cycle_done    <= 1'b0;
    end else begin
      addr_drive_en <= (state_r == CYC_IDLE) && cycle_start && hit_region != REGION_NONE &&
                       !addr_off_sel && !global_mem_addr_off_r;
      if (state_r == CYC_IDLE && cycle_start) begin
        case (hit_region)
          REGION_UPPER: bus_is_x8 <= up_if.width_sel && !up_if.dram_on;
          REGION_LOWER: bus_is_x8 <= lo_if.width_sel && !lo_if.dram_on;
          default:      bus_is_x8 <= 1'b0;
        endcase
      end
      data_phase <= in_cycle_nxt && state_r != CYC_IDLE;
      cycle_done <= state_r == CYC_DATA && (ready_in || ready_ign_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_upper_dram_hold: assert property (@(posedge pclk) disable iff (!presetn)
    up_if.dram_on && $stable(up_if.dram_on) |=> upper_select_out_n)
    else $error("upper select asserted in DRAM mode");
  chk_lower_idle_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !lower_written_r |-> lower_select_out_n)
    else $error("lower select active before configuration");
  chk_dram_width_x16: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CYC_IDLE && cycle_start && hit_region == REGION_UPPER && up_if.dram_on
    |=> !bus_is_x8)
    else $error("DRAM region not 16-bit");
  chk_width_select: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CYC_IDLE && cycle_start && hit_region == REGION_LOWER && !lo_if.dram_on
    |=> bus_is_x8 == $past(lo_if.width_sel))
    else $error("lower width mismatch");
  chk_periph_width: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CYC_IDLE && cycle_start && hit_region == REGION_PERIPH |=> !bus_is_x8)
    else $error("peripheral overlap not 16-bit");
  chk_addr_global_off: assert property (@(posedge pclk) disable iff (!presetn)
    global_mem_addr_off_r && $stable(global_mem_addr_off_r) |=> !addr_drive_en)
    else $error("address driven while globally off");
  chk_wait_three: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CYC_ADDR && wait_left_r == 2'b11 |=> state_r == CYC_WAIT [*3] ##1
    state_r == CYC_DATA)
    else $error("three waits not inserted");
  chk_ready_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CYC_DATA && ready_ign_sel |=> state_r == CYC_IDLE)
    else $error("ready not ignored");
  chk_strap_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
    addr_strap_low_r && state_r == CYC_IDLE && cycle_start && hit_region == REGION_UPPER &&
    !global_mem_addr_off_r |=> addr_drive_en)
    else $error("address disable acted with strap low");
  chk_one_select: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({!upper_select_out_n, !lower_select_out_n, !midrange_select_three_n}))
    else $error("more than one select active");

endmodule : memory_chip_select_decoder

// ### bench/mem_ready_model.sv
// Far-side memory model that answers on the external ready lines
`timescale 1ns/100ps
module mem_ready_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Cycle view and stall control from the bench
  input  wire logic       data_phase,
  input  wire logic [3:0] stall,
  input  wire logic       stall_async,
  // Ready answers
  output logic            sync_ready_in,
  output logic            async_ready_in
);
  logic [3:0] held_r;
  logic       toggle_r;
  logic       hold_now;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r   <= 4'h0;
      toggle_r <= 1'b0;
    end else begin
      toggle_r <= !toggle_r;
      held_r   <= data_phase ? held_r + 4'h1 : 4'h0;
    end
  end
  // Outside a data phase the lines toggle, so sampling them early cannot pass by luck
  assign hold_now = data_phase && (held_r < stall);
  always_comb begin
    sync_ready_in  = data_phase ? !(hold_now && !stall_async) : toggle_r;
    async_ready_in = data_phase ? !(hold_now && stall_async) : !toggle_r;
  end
endmodule : mem_ready_model

// ### bench/tb_memory_chip_select_decoder.sv
// Self-checking testbench for the memory chip select decoder
`timescale 1ns/100ps
`include "mem_select_map.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_memory_chip_select_decoder;
  typedef struct {
    logic [15:0] up;
    logic [15:0] lo;
    logic        sys;
    logic [19:0] a;
    logic        ps;
    logic [2:0]  sel;
    logic        ad;
    logic        x8;
    int          nd;
  } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic        watchdog_reset, addr_enable_strap_n, byte_boot_strap, cycle_start;
  logic        peripheral_select, sync_ready_in, async_ready_in, stall_async;
  logic        upper_select_out_n, lower_select_out_n, midrange_select_one_n;
  logic        midrange_select_two_n, midrange_select_three_n;
  logic        addr_drive_en, bus_is_x8, data_phase, cycle_done, ad, x8;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] cycle_addr;
  logic [3:0]  stall;
  logic [2:0]  s;
  logic [1:0]  cs;
  int          nd, fail_count, n_compared;
  // Selects compared as {upper, lower, row strobe hi bank}
  row_t rows[16] = '{
    '{16'hf000, 16'h0000, 0, 20'hf_0000, 0, 3'b011, 1, 0, 1},
    '{16'hf021, 16'h0000, 0, 20'hf_ffff, 0, 3'b011, 1, 1, 2},
    '{16'he002, 16'h0000, 0, 20'he_0000, 0, 3'b011, 1, 0, 3},
    '{16'hc003, 16'h3000, 0, 20'hc_0000, 0, 3'b011, 1, 0, 4},
    '{16'h8000, 16'h0000, 0, 20'h8_0000, 0, 3'b011, 1, 0, 1},
    '{16'hc000, 16'h7000, 0, 20'h7_ffff, 0, 3'b101, 1, 0, 1},
    '{16'hf000, 16'h1021, 0, 20'h1_ffff, 0, 3'b101, 1, 1, 2},
    '{16'hf000, 16'h3082, 0, 20'h3_ffff, 0, 3'b101, 0, 0, 3},
    '{16'hf000, 16'h0000, 0, 20'h0_ffff, 0, 3'b101, 1, 0, 1},
    '{16'hf080, 16'h0000, 0, 20'hf_0000, 0, 3'b011, 0, 0, 1},
    '{16'hf000, 16'h0000, 1, 20'hf_0000, 0, 3'b011, 0, 0, 1},
    '{16'hf0e4, 16'h0000, 0, 20'hf_0000, 0, 3'b110, 0, 0, 1},
    '{16'hf0c0, 16'h0000, 0, 20'hf_0100, 1, 3'b000, 1, 0, 1},
    '{16'hf0c0, 16'h0000, 1, 20'hf_0100, 1, 3'b000, 0, 0, 1},
    '{16'hf000, 16'h00e0, 0, 20'h0_0000, 0, 3'b101, 0, 0, 1},
    '{16'hf000, 16'h00c0, 0, 20'h0_0100, 1, 3'b000, 1, 0, 1}};
  logic [15:0] su[4] = '{16'hf000, 16'hf000, 16'hf004, 16'hf040};
  int          sn[4] = '{3, 2, 3, 3};
  int          se[4] = '{4, 3, 1, 1};

  memory_chip_select_decoder memory_chip_select_decoder_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .watchdog_reset, .addr_enable_strap_n,
    .byte_boot_strap, .cycle_start, .cycle_addr, .peripheral_select, .sync_ready_in,
    .async_ready_in, .upper_select_out_n, .lower_select_out_n, .midrange_select_one_n,
    .midrange_select_two_n, .midrange_select_three_n, .addr_drive_en, .bus_is_x8,
    .data_phase, .cycle_done);
  mem_ready_model mem_ready_model_inst (.pclk, .presetn, .data_phase, .stall, .stall_async,
    .sync_ready_in, .async_ready_in);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic bb, input logic aen_n);
    presetn <= 1'b0;
    byte_boot_strap <= bb;
    addr_enable_strap_n <= aen_n;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  // Registers change only between memory cycles, never during one
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mem_cycle(input logic [19:0] a, input logic ps);
    @(posedge pclk);
    cycle_start <= 1'b1;
    cycle_addr <= a;
    peripheral_select <= ps;
    @(posedge pclk);
    cycle_start <= 1'b0;
    peripheral_select <= 1'b0;
    // Address drive stands only in the first output cycle
    #1;
    s = {upper_select_out_n, lower_select_out_n, midrange_select_three_n};
    cs = {midrange_select_one_n, midrange_select_two_n};
    ad = addr_drive_en;
    x8 = bus_is_x8;
    nd = 0;
    while (cycle_done !== 1'b1) begin
      @(posedge pclk);
      #1;
      if (cycle_done !== 1'b1 && data_phase === 1'b1) nd++;
    end
  endtask : mem_cycle
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    #60000;
    fail_count++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, cycle_start, peripheral_select, watchdog_reset} = '0;
    {paddr, pwdata, cycle_addr, stall, stall_async} = '0;
    presetn = 1'b0;
    do_reset(1'b0, 1'b1);
    apb(0, `UPPER_CFG_ADDR, 0, rd);
    `CHK("upper reset", {16'h0000, `UPPER_CFG_RESET | 16'h0020}, rd)
    apb(0, `LOWER_CFG_ADDR, 0, rd);
    `CHK("lower reset", {16'h0000, `LOWER_CFG_RESET}, rd)
    mem_cycle(20'h0_0000, 0);
    `CHK("lower idle", 1'b1, s[1])
    mem_cycle(20'hf_0000, 0);
    `CHK("boot select", 3'b011, s)
    `CHK("boot width", 1'b1, x8)
    `CHK("boot waits", 4, nd)
    foreach (rows[i]) begin
      apb(1, `UPPER_CFG_ADDR, rows[i].up, rd);
      apb(1, `LOWER_CFG_ADDR, rows[i].lo, rd);
      apb(1, `SYSCFG_ADDR, rows[i].sys, rd);
      mem_cycle(rows[i].a, rows[i].ps);
      if (!rows[i].ps) `CHK("selects", rows[i].sel, s)
      if (!rows[i].ps) `CHK("column strobes", {2{rows[i].sel[0] &&
        !(!rows[i].sel[1] && rows[i].lo[`FLD_DRAM_ON])}}, cs)
      `CHK("addr drive", rows[i].ad, ad)
      `CHK("x8", rows[i].x8, x8)
      if (!rows[i].ps) `CHK("data cycles", rows[i].nd, nd)
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, `UPPER_CFG_ADDR, su[i], rd);
      stall <= 4'(sn[i]);
      stall_async <= i[0];
      mem_cycle(20'hf_0000, 0);
      `CHK("stalled cycles", se[i], nd)
    end
    stall <= 4'h0;
    apb(1, `LOWER_CFG_ADDR, 32'h0000_ffff, rd);
    apb(0, `LOWER_CFG_ADDR, 0, rd);
    `CHK("lower access", {16'h0000, (`LOWER_CFG_RESET & ~`CFG_WR_MASK) | `CFG_WR_MASK}, rd)
    apb(0, 12'h3b0, 0, rd);
    `CHK("unmapped data", 32'h0000_0000, rd)
    `CHK("unmapped error", 1'b1, serr)
    apb(1, `UPPER_CFG_ADDR, 32'h0000_f0c0, rd);
    @(posedge pclk);
    watchdog_reset <= 1'b1;
    @(posedge pclk);
    watchdog_reset <= 1'b0;
    apb(0, `UPPER_CFG_ADDR, 0, rd);
    `CHK("upper after watchdog", {16'h0000, `UPPER_CFG_RESET}, rd)
    mem_cycle(20'h0_0000, 0);
    `CHK("lower after watchdog", 1'b1, s[1])
    mem_cycle(20'hf_0000, 0);
    `CHK("upper after watchdog", 3'b011, s)
    `CHK("kept width", 1'b0, x8)
    do_reset(1'b1, 1'b0);
    apb(1, `UPPER_CFG_ADDR, 32'h0000_f0a0, rd);
    apb(0, `UPPER_CFG_ADDR, 0, rd);
    `CHK("locked width", {16'h0000, ((`UPPER_CFG_RESET & ~`CFG_WR_MASK) |
         (16'hf0a0 & `CFG_WR_MASK)) & ~16'h0020}, rd)
    mem_cycle(20'hf_0000, 0);
    `CHK("strap addr drive", 1'b1, ad)
    `CHK("strap width", 1'b0, x8)
    tally_and_finish;
  end
endmodule : tb_memory_chip_select_decoder
